// ### logic/nb_misc_regs_defines.vh
// Offsets, field positions, masks and reset values of the misc indirect bank
`ifndef NB_MISC_REGS_DEFINES_VH
`define NB_MISC_REGS_DEFINES_VH
// -----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define IX_MAIN 6'h00
`define IX_IODBG 6'h01
`define IX_SPARE1 6'h02
`define IX_STRSEL 6'h03
`define IX_STRVAL 6'h04
`define IX_DFTA 6'h05
`define IX_DFTB 6'h06
`define IX_TXGATE 6'h07
`define IX_LINK 6'h08
`define IX_DMAARB 6'h09
`define IX_CSRLIM 6'h0A
`define IX_ORDER 6'h0B
`define IX_P2P 6'h0C
`define IX_ISOLO 6'h0E
`define IX_ISOHI 6'h0F
`define IX_DFTC 6'h10
`define IX_BUSNUM 6'h11
`define IX_COREARB 6'h12
`define IX_TOM 6'h16
`define IX_MMBASE 6'h17
`define IX_MMLIM 6'h18
`define IX_BIF 6'h1E
`define IX_INTPIN 6'h1F
`define IX_REMAPA 6'h20
`define IX_REMAPB 6'h21
`define IX_LATCTL 6'h30
`define IX_LATVAL 6'h31
`define IX_PHY2 6'h32
`define IX_PHY3 6'h33
`define IX_PHY4 6'h34
`define IX_PHY5 6'h35
`define IX_PHY6 6'h36
`define IX_PHY7 6'h37
`define IX_PHY8 6'h38
// -----------------------------------------------------------------
// Writable bit masks
// -----------------------------------------------------------------
`define WM_ALL 32'hFFFFFFFF
`define WM_MAIN 32'hFFFF04FF
`define WM_LOW16 32'h0000FFFF
`define WM_LOW8 32'h000000FF
`define WM_DFTB 32'h000FFFFF
`define WM_ORDER 32'h1DFF3F9F
`define WM_P2P 32'h000F7FFC
`define WM_ISOLO 32'hFFFFFFC0
`define WM_DFTC 32'hFFFF0000
`define WM_BUSNUM 32'h000001FF
`define WM_TOM 32'hFFFF0001
`define WM_MMIO 32'hFFFFFF00
`define WM_BIF 32'h000003FF
`define WM_REMAPA 32'hFFFFFFF3
`define WM_REMAPB 32'h00000FFF
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RV_MAIN 32'h00000402
`define RV_DFTA 32'h32100000
`define RV_LINK 32'h07E00030
`define RV_ORDER 32'h00400100
`define RV_P2P 32'h00001700
`define RV_DFTC 32'h76540000
`define RV_COREARB 32'h55555555
`define RV_ONE 32'h00000001
`define RV_REMAPA 32'h00000002
`define RV_PHY4 32'hCBFA0022
`define RV_PHY5 32'h018CA887
`define RV_PHY6 32'h00000C63
`define RV_PHY7 32'h00200000
`define RV_PHY8 32'h094C3396
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define B_TESTMODE 13
`define B_SERMODE 14
`define B_GFXV3 4
`define B_GFXV3ENH 5
`define B_MREQERR 16
`define B_MAPERR 17
`define B_COMIN 20
`define B_LATEN 0
`define B_LATFRZ 1
`endif

// ### logic/northbridge_misc_indirect_regs.v
// Misc indirect register bank with a classic Wishbone slave port
//
// Design decision made here: the Wishbone interface to the registers.
`include "nb_misc_regs_defines.vh"
`default_nettype none

module northbridge_misc_indirect_regs (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave port
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Asynchronous status pins, synchronised below
  input wire test_mode_i,
  input wire serial_port_mode_i,
  input wire multi_request_error_i,
  input wire memory_map_config_error_i,
  input wire [13:0] debug_status_i,
  input wire [15:0] spare_status_i,
  input wire com_port_in_i,
  input wire [15:0] debug_readback_i,
  input wire [31:0] strap_data_i,
  input wire latency_event_i,
  // Control outputs, each a stored register bit
  output wire conceal_host_gfxport_capability_o,
  output wire conceal_bridge_gfxport_capability_o,
  output wire conceal_aperture_base_o,
  output wire conceal_cfgspace_base_o,
  output wire gfxport_v3_register_mode_o,
  output wire gfxport_v3_enhanced_mode_o,
  output wire [1:0] graphics_training_hold_o,
  output wire [6:0] general_training_hold_o,
  output wire [3:0] graphics_port_split_o,
  output wire [7:0] strap_select_o,
  output wire [9:0] interface_spare_bits_o
);

  // -----------------------------------------------------------------
  // Register mask and reset tables
  // -----------------------------------------------------------------
  // Word map, index then contents
  //   0x00 main_control: conceal bits 3:0, port modes 5:4, pin flags 14:13 read-only
  //   0x01 io_ctrl_debug: 15:0 stored, error flags 17:16 and status 31:18 read-only
  //   0x02 spare_word_one: 15:0 stored, spare status 31:16 read-only
  //   0x03 strap_readback_select: select 7:0, also driven out to the strap mux
  //   0x04 strap_readback_value: synchronised strap word, read-only
  //   0x05 test_debug_control_a: debug bus selects, all stored
  //   0x06 test_debug_control_b: 19:0 stored, serial input 20 read-only
  //   0x07 link_txclk_gating: transmit clock gating controls, all stored
  //   0x08 link_reset_training_cfg: link resets, training holds, port split
  //   0x09 dma_arbitration: all stored
  //   0x0A csr_delay_limit: all stored
  //   0x0B io_ctrl_ordering: ordering controls, gaps read zero
  //   0x0C peer_to_peer_control: bridge disables and routing controls
  //   0x0E isochronous_map_low: address bits 31:6
  //   0x0F isochronous_map_high: address bits 7:0
  //   0x10 test_debug_control_c: readback 15:0 read-only, selects 31:16
  //   0x11 bus_number_control: bus number and latency mode
  //   0x12 link_core_arbitration: two 16-bit weights
  //   0x16 top_of_memory_for_pci: follow flag 0, boundary 31:16
  //   0x17 mmio_window_base: bits 31:8
  //   0x18 mmio_window_limit: bits 31:8
  //   0x1E bus_interface_spare: spare bits 9:0, also driven out
  //   0x1F interrupt_pin_config: bits 7:0
  //   0x20 device_remap_a: enable, remap disable and port maps
  //   0x21 device_remap_b: three port maps in 11:0
  //   0x30 latency_counter_control: enable 0, freeze 1, selects 7:2 stored only
  //   0x31 latency_counter_value: live count, read-only
  //   0x32 to 0x38 phy_config_word_2 to phy_config_word_8: opaque, all stored
  // Every other index reads zero and drops writes

  // Unmapped indexes get mask zero: they read zero and drop writes
  function [31:0] reg_mask;
    input [5:0] ix;
    begin
      case (ix)
        // Host bridge control, pin status and strap access
        `IX_MAIN: reg_mask = `WM_MAIN;
        `IX_IODBG: reg_mask = `WM_LOW16;
        `IX_SPARE1: reg_mask = `WM_LOW16;
        `IX_STRSEL: reg_mask = `WM_LOW8;
        // Test and debug controls
        `IX_DFTA: reg_mask = `WM_ALL;
        `IX_DFTB: reg_mask = `WM_DFTB;
        // Link, I/O controller and debug words
        `IX_TXGATE: reg_mask = `WM_ALL;
        `IX_LINK: reg_mask = `WM_ALL;
        `IX_DMAARB: reg_mask = `WM_ALL;
        `IX_CSRLIM: reg_mask = `WM_ALL;
        `IX_ORDER: reg_mask = `WM_ORDER;
        `IX_P2P: reg_mask = `WM_P2P;
        `IX_ISOLO: reg_mask = `WM_ISOLO;
        `IX_ISOHI: reg_mask = `WM_LOW8;
        `IX_DFTC: reg_mask = `WM_DFTC;
        `IX_BUSNUM: reg_mask = `WM_BUSNUM;
        `IX_COREARB: reg_mask = `WM_ALL;
        // Memory windows, spares and device remap
        `IX_TOM: reg_mask = `WM_TOM;
        `IX_MMBASE: reg_mask = `WM_MMIO;
        `IX_MMLIM: reg_mask = `WM_MMIO;
        `IX_BIF: reg_mask = `WM_BIF;
        `IX_INTPIN: reg_mask = `WM_LOW8;
        `IX_REMAPA: reg_mask = `WM_REMAPA;
        `IX_REMAPB: reg_mask = `WM_REMAPB;
        // Latency counter control, low byte only
        `IX_LATCTL: reg_mask = `WM_LOW8;
        // Opaque link PHY words, fully writable
        `IX_PHY2: reg_mask = `WM_ALL;
        `IX_PHY3: reg_mask = `WM_ALL;
        `IX_PHY4: reg_mask = `WM_ALL;
        `IX_PHY5: reg_mask = `WM_ALL;
        `IX_PHY6: reg_mask = `WM_ALL;
        `IX_PHY7: reg_mask = `WM_ALL;
        `IX_PHY8: reg_mask = `WM_ALL;
        default: reg_mask = 32'h00000000;
      endcase
    end
  endfunction

  // Reset image of each stored word
  function [31:0] reg_reset;
    input [5:0] ix;
    begin
      case (ix)
        // Control words with non-zero defaults
        `IX_MAIN: reg_reset = `RV_MAIN;
        `IX_DFTA: reg_reset = `RV_DFTA;
        `IX_LINK: reg_reset = `RV_LINK;
        `IX_ORDER: reg_reset = `RV_ORDER;
        `IX_P2P: reg_reset = `RV_P2P;
        `IX_DFTC: reg_reset = `RV_DFTC;
        `IX_COREARB: reg_reset = `RV_COREARB;
        // Memory boundary, pin config and remap defaults
        `IX_TOM: reg_reset = `RV_ONE;
        `IX_INTPIN: reg_reset = `RV_ONE;
        `IX_REMAPA: reg_reset = `RV_REMAPA;
        // Opaque link PHY defaults
        `IX_PHY2: reg_reset = `RV_ONE;
        `IX_PHY4: reg_reset = `RV_PHY4;
        `IX_PHY5: reg_reset = `RV_PHY5;
        `IX_PHY6: reg_reset = `RV_PHY6;
        `IX_PHY7: reg_reset = `RV_PHY7;
        `IX_PHY8: reg_reset = `RV_PHY8;
        // Every other word powers up zero
        default: reg_reset = 32'h00000000;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  localparam HW_W = 84;
  wire [HW_W-1:0] hw_raw;
  reg [HW_W-1:0] sync1_ff;
  reg [HW_W-1:0] sync2_ff;

  assign hw_raw = {
    latency_event_i,
    strap_data_i,
    debug_readback_i,
    com_port_in_i,
    spare_status_i,
    debug_status_i,
    memory_map_config_error_i,
    multi_request_error_i,
    serial_port_mode_i,
    test_mode_i
  };

  // All status pins are asynchronous; first stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= {HW_W{1'b0}};
      sync2_ff <= {HW_W{1'b0}};
    end else begin
      sync1_ff <= hw_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Bit positions of each pin group inside the synchroniser vector
  localparam SY_TEST = 0;
  localparam SY_SER = 1;
  localparam SY_MREQ = 2;
  localparam SY_MAP = 3;
  localparam SY_DBG = 4;
  localparam SY_SPARE = 18;
  localparam SY_COM = 34;
  localparam SY_RB = 35;
  localparam SY_STRAP = 51;
  localparam SY_LAT = 83;

  // Named views of the synchronised status
  wire test_mode_s;
  wire serial_mode_s;
  wire mreq_err_s;
  wire map_err_s;
  wire [13:0] dbg_stat_s;
  wire [15:0] spare_stat_s;
  wire com_in_s;
  wire [15:0] dbg_rb_s;
  wire [31:0] strap_s;
  wire lat_event_s;

  assign test_mode_s = sync2_ff[SY_TEST];
  assign serial_mode_s = sync2_ff[SY_SER];
  assign mreq_err_s = sync2_ff[SY_MREQ];
  assign map_err_s = sync2_ff[SY_MAP];
  assign dbg_stat_s = sync2_ff[SY_DBG +: 14];
  assign spare_stat_s = sync2_ff[SY_SPARE +: 16];
  assign com_in_s = sync2_ff[SY_COM];
  assign dbg_rb_s = sync2_ff[SY_RB +: 16];
  assign strap_s = sync2_ff[SY_STRAP +: 32];
  assign lat_event_s = sync2_ff[SY_LAT];

  // -----------------------------------------------------------------
  // Wishbone request decode
  // -----------------------------------------------------------------
  wire [5:0] idx;
  wire req;
  wire wr_en;
  wire [31:0] be_mask;

  assign idx = adr_i[7:2];
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr_en = req & we_i;
  assign be_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // -----------------------------------------------------------------
  // Stored registers
  // -----------------------------------------------------------------
  reg [31:0] regs_ff [0:63];
  wire [31:0] nxt_regs [0:63];
  integer k;

  // Read-only bits are outside the mask, so software cannot touch them
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : slot
      localparam [31:0] GW = g;
      localparam [5:0] GI = GW[5:0];
      wire [31:0] wm;
      assign wm = reg_mask(GI) & be_mask;
      assign nxt_regs[g] = (wr_en && idx == GI) ? ((regs_ff[g] & ~wm) | (dat_i & wm)) : regs_ff[g];
    end
  endgenerate

  // One process owns the whole array, so every word has a single driver
  always @(posedge clk_i) begin
    for (k = 0; k < 64; k = k + 1) begin
      if (rst_i) begin
        regs_ff[k] <= reg_reset(k[5:0]);
      end else begin
        regs_ff[k] <= nxt_regs[k];
      end
    end
  end

  // -----------------------------------------------------------------
  // Latency performance counter
  // -----------------------------------------------------------------
  reg [31:0] lat_cnt_ff;
  wire lat_en;
  wire lat_frz;

  assign lat_en = regs_ff[`IX_LATCTL][`B_LATEN];
  assign lat_frz = regs_ff[`IX_LATCTL][`B_LATFRZ];

  // Freeze holds the count for reading; disabling clears it for a new run
  always @(posedge clk_i) begin
    if (rst_i) begin
      lat_cnt_ff <= 32'h00000000;
    end else if (!lat_en) begin
      lat_cnt_ff <= 32'h00000000;
    end else if (!lat_frz && lat_event_s) begin
      lat_cnt_ff <= lat_cnt_ff + 32'h00000001; // Wraps at full scale
    end
  end

  // -----------------------------------------------------------------
  // Read path with hardware state overlay
  // -----------------------------------------------------------------
  reg [31:0] rd;

  // Stored word with live pin state laid over the read-only fields
  always @* begin
    rd = regs_ff[idx];
    case (idx)
      `IX_MAIN: begin
        rd[`B_TESTMODE] = test_mode_s;
        rd[`B_SERMODE] = serial_mode_s;
      end
      `IX_IODBG: begin
        rd[`B_MREQERR] = mreq_err_s;
        rd[`B_MAPERR] = map_err_s;
        rd[31:18] = dbg_stat_s;
      end
      `IX_SPARE1: begin
        rd[31:16] = spare_stat_s;
      end
      `IX_STRVAL: begin
        rd = strap_s;
      end
      `IX_DFTB: begin
        rd[`B_COMIN] = com_in_s;
      end
      `IX_DFTC: begin
        rd[15:0] = dbg_rb_s;
      end
      `IX_LATVAL: begin
        rd = lat_cnt_ff;
      end
      default: begin
        rd = regs_ff[idx];
      end
    endcase
  end

  // Single wait-free answer; unmapped words ack with zero data
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= rd;
      end
    end
  end

  // -----------------------------------------------------------------
  // Control outputs, each straight from a stored bit
  // -----------------------------------------------------------------
  // Conceal bits: set hides, clear exposes
  assign conceal_host_gfxport_capability_o = regs_ff[`IX_MAIN][0];
  assign conceal_bridge_gfxport_capability_o = regs_ff[`IX_MAIN][1];
  assign conceal_aperture_base_o = regs_ff[`IX_MAIN][2];
  assign conceal_cfgspace_base_o = regs_ff[`IX_MAIN][3];

  // Graphics-port 3.0 modes
  assign gfxport_v3_register_mode_o = regs_ff[`IX_MAIN][`B_GFXV3];
  assign gfxport_v3_enhanced_mode_o = regs_ff[`IX_MAIN][`B_GFXV3ENH];

  // Training holds: high blocks training of that link
  assign graphics_training_hold_o = regs_ff[`IX_LINK][5:4];
  assign general_training_hold_o = regs_ff[`IX_LINK][26:20];

  // Port split: 0 port A only, 1 ports A and B
  assign graphics_port_split_o = regs_ff[`IX_LINK][11:8];

  // Strap readback select drives the external strap mux
  assign strap_select_o = regs_ff[`IX_STRSEL][7:0];

  // Spare bits 9:0; upper bits are not stored and read zero
  assign interface_spare_bits_o = regs_ff[`IX_BIF][9:0];

endmodule

`default_nettype wire

// ### verif/nb_misc_regs_properties.sv
// Port-level checks for the misc indirect register bank
`default_nettype none
module nb_misc_regs_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [31:0] strap_data_i,
  input wire logic conceal_host_gfxport_capability_o,
  input wire logic conceal_bridge_gfxport_capability_o,
  input wire logic conceal_aperture_base_o,
  input wire logic conceal_cfgspace_base_o,
  input wire logic gfxport_v3_register_mode_o,
  input wire logic gfxport_v3_enhanced_mode_o,
  input wire logic [1:0] graphics_training_hold_o,
  input wire logic [6:0] general_training_hold_o,
  input wire logic [3:0] graphics_port_split_o,
  input wire logic [9:0] interface_spare_bits_o
);
  // --------------------
  // Request decode
  // --------------------
  // A request counts only while no answer is pending
  wire logic take = cyc_i && stb_i && !ack_o;
  wire logic wr = take && we_i;
  wire logic [5:0] ix = adr_i[7:2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------------------
  // Assertions
  // --------------------
  a_ack_after_take: assert property (take |=> ack_o) else $error("no answer after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("answer held too long");
  a_reset_state: assert property ($fell(rst_i) |-> conceal_bridge_gfxport_capability_o
    && !conceal_host_gfxport_capability_o && !conceal_aperture_base_o && !conceal_cfgspace_base_o
    && !gfxport_v3_register_mode_o && !gfxport_v3_enhanced_mode_o
    && graphics_training_hold_o == 2'h3 && general_training_hold_o == 7'h7E) else $error("bad reset outputs");
  a_conceal_write: assert property (wr && ix == 6'h00 && sel_i[0] |=>
    {conceal_cfgspace_base_o, conceal_aperture_base_o, conceal_bridge_gfxport_capability_o,
    conceal_host_gfxport_capability_o} == $past(dat_i[3:0])) else $error("conceal bits wrong");
  a_mode_write: assert property (wr && ix == 6'h00 && sel_i[0] |=>
    {gfxport_v3_enhanced_mode_o, gfxport_v3_register_mode_o} == $past(dat_i[5:4])) else $error("mode bits wrong");
  a_hold_write: assert property (wr && ix == 6'h08 && sel_i == 4'hF |=>
    graphics_training_hold_o == $past(dat_i[5:4]) && general_training_hold_o == $past(dat_i[26:20]))
    else $error("training holds wrong");
  a_split_write: assert property (wr && ix == 6'h08 && sel_i[1] |=>
    graphics_port_split_o == $past(dat_i[11:8])) else $error("port split wrong");
  a_spare_write: assert property (wr && ix == 6'h1E && sel_i[1:0] == 2'h3 |=>
    interface_spare_bits_o == $past(dat_i[9:0])) else $error("spare bits wrong");
  // Read data is the strap word as sampled two edges before the taking edge
  a_strap_read: assert property (take && !we_i && ix == 6'h04 && !$past(rst_i, 1) && !$past(rst_i, 2) |=>
    dat_o == $past(strap_data_i, 3)) else $error("strap readback wrong");
endmodule

bind northbridge_misc_indirect_regs nb_misc_regs_properties i_nb_misc_regs_properties (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .strap_data_i(strap_data_i),
  .conceal_host_gfxport_capability_o(conceal_host_gfxport_capability_o),
  .conceal_bridge_gfxport_capability_o(conceal_bridge_gfxport_capability_o),
  .conceal_aperture_base_o(conceal_aperture_base_o),
  .conceal_cfgspace_base_o(conceal_cfgspace_base_o),
  .gfxport_v3_register_mode_o(gfxport_v3_register_mode_o),
  .gfxport_v3_enhanced_mode_o(gfxport_v3_enhanced_mode_o),
  .graphics_training_hold_o(graphics_training_hold_o),
  .general_training_hold_o(general_training_hold_o),
  .graphics_port_split_o(graphics_port_split_o),
  .interface_spare_bits_o(interface_spare_bits_o)
);
`default_nettype wire

// ### verif/northbridge_misc_indirect_regs_tb.sv
// Directed bench for the misc indirect register bank
`default_nettype none
module northbridge_misc_indirect_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, strap_data_i = 32'hA5C31E77, rd, r1;
  logic test_mode_i = 1'b1, serial_port_mode_i = 1'b1, multi_request_error_i = 1'b1;
  logic memory_map_config_error_i = 1'b0, com_port_in_i = 1'b1, latency_event_i = 1'b1;
  logic [13:0] debug_status_i = 14'h2AAA;
  logic [15:0] spare_status_i = 16'hBEEF, debug_readback_i = 16'h1234;
  logic conceal_host_gfxport_capability_o, conceal_bridge_gfxport_capability_o, conceal_aperture_base_o;
  logic conceal_cfgspace_base_o, gfxport_v3_register_mode_o, gfxport_v3_enhanced_mode_o;
  logic [1:0] graphics_training_hold_o;
  logic [6:0] general_training_hold_o;
  logic [3:0] graphics_port_split_o;
  logic [7:0] strap_select_o;
  logic [9:0] interface_spare_bits_o;
  int fail_count = 0, checks_done = 0, cycles = 0;
  logic [5:0] rix [11] = '{6'h00, 6'h08, 6'h1E, 6'h03, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38};
  logic [31:0] rval [11] = '{32'h00006402, 32'h07E00030, 32'h0, 32'h0, 32'h1, 32'h0, 32'hCBFA0022,
    32'h018CA887, 32'h00000C63, 32'h00200000, 32'h094C3396};
  // Unmapped 0x0D and 0x3F must read zero after an all-ones write
  logic [5:0] oix [11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h10, 6'h1E, 6'h31, 6'h0D, 6'h3F};
  logic [31:0] oval [11] = '{32'hFFFF64FF, 32'hAAA9FFFF, 32'hBEEFFFFF, 32'h000000FF, 32'hA5C31E77,
    32'h001FFFFF, 32'hFFFF1234, 32'h000003FF, 32'h0, 32'h0, 32'h0};
  northbridge_misc_indirect_regs i_northbridge_misc_indirect_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .test_mode_i(test_mode_i),
    .serial_port_mode_i(serial_port_mode_i), .multi_request_error_i(multi_request_error_i),
    .memory_map_config_error_i(memory_map_config_error_i), .debug_status_i(debug_status_i),
    .spare_status_i(spare_status_i), .com_port_in_i(com_port_in_i), .debug_readback_i(debug_readback_i),
    .strap_data_i(strap_data_i), .latency_event_i(latency_event_i),
    .conceal_host_gfxport_capability_o(conceal_host_gfxport_capability_o),
    .conceal_bridge_gfxport_capability_o(conceal_bridge_gfxport_capability_o),
    .conceal_aperture_base_o(conceal_aperture_base_o), .conceal_cfgspace_base_o(conceal_cfgspace_base_o),
    .gfxport_v3_register_mode_o(gfxport_v3_register_mode_o),
    .gfxport_v3_enhanced_mode_o(gfxport_v3_enhanced_mode_o),
    .graphics_training_hold_o(graphics_training_hold_o), .general_training_hold_o(general_training_hold_o),
    .graphics_port_split_o(graphics_port_split_o), .strap_select_o(strap_select_o),
    .interface_spare_bits_o(interface_spare_bits_o)
  );
  // Clock and hang guard
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  // --------------------
  // Tasks
  // --------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Classic single cycle; only the bench timeout ends the wait for an answer
  task automatic bus(logic w, logic [5:0] ix, logic [31:0] d, logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'b00};
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    // Answer is due one cycle after the taking edge, so on the second edge
    check("ack delay", n, 32'h00000002);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rc(string what, logic [5:0] ix, logic [31:0] exp);
    bus(1'b0, ix, 32'h0, 4'hF);
    check(what, rd, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Status overlays read the reset zeros until both sync stages have filled
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 11; k++) rc("reset value", rix[k], rval[k]);
    for (int k = 0; k < 11; k++) begin
      bus(1'b1, oix[k], 32'hFFFFFFFF, 4'hF);
      rc("all ones", oix[k], oval[k]);
    end
    check("outputs set", {8'h0, strap_select_o, interface_spare_bits_o, gfxport_v3_enhanced_mode_o,
      gfxport_v3_register_mode_o, conceal_cfgspace_base_o, conceal_aperture_base_o,
      conceal_bridge_gfxport_capability_o, conceal_host_gfxport_capability_o}, 32'h00FFFFFF);
    bus(1'b1, 6'h00, 32'h0, 4'hF);
    rc("main clear", 6'h00, 32'h00006000);
    // Strap pins move; readback follows after the two sync stages
    strap_data_i <= 32'h5A3CE188;
    repeat (4) @(posedge clk_i);
    rc("strap moved", 6'h04, 32'h5A3CE188);
    bus(1'b1, 6'h08, 32'h00100100, 4'hF);
    rc("link cfg", 6'h08, 32'h00100100);
    check("holds", {19'h0, graphics_training_hold_o, general_training_hold_o, graphics_port_split_o}, 32'h11);
    bus(1'b1, 6'h08, 32'hFFFFFFFF, 4'h2);
    rc("link byte", 6'h08, 32'h0010FF00);
    check("split", {28'h0, graphics_port_split_o}, 32'hF);
    // Counter runs, freezes, ignores writes, then clears
    bus(1'b1, 6'h30, 32'h1, 4'hF);
    repeat (10) @(posedge clk_i);
    bus(1'b1, 6'h30, 32'h3, 4'hF);
    bus(1'b0, 6'h31, 32'h0, 4'hF);
    r1 = rd;
    check("counting", {31'h0, r1 != 32'h0}, 32'h1);
    bus(1'b1, 6'h31, 32'h0, 4'hF);
    rc("frozen", 6'h31, r1);
    bus(1'b1, 6'h30, 32'h0, 4'hF);
    repeat (3) @(posedge clk_i);
    rc("cleared", 6'h31, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
